/* File: ssic_pkg.sv */
// shared constants and types for the status and interrupt control block
package ssic_pkg;

  // bus and array geometry
  localparam int SSIC_AW = 8;
  localparam int SSIC_DW = 8;
  localparam int SSIC_NUM_SR = 9;
  localparam int SSIC_SRC_W = SSIC_NUM_SR * SSIC_DW;

  // register offsets
  localparam logic [7:0] SSIC_OFF_MASTER = 8'h00;
  localparam logic [7:0] SSIC_OFF_SUM_LO = 8'h14;
  localparam logic [7:0] SSIC_OFF_SUM_HI = 8'h15;
  localparam logic [7:0] SSIC_OFF_SR_BASE = 8'h16;
  localparam logic [7:0] SSIC_OFF_IMR_BASE = 8'h20;
  localparam logic [7:0] SSIC_OFF_INFO_LATCHED = 8'h29;
  localparam logic [7:0] SSIC_OFF_INFO_LIVE = 8'h2a;

  // master control field layout
  localparam int SSIC_MC_SRST = 0;
  localparam int SSIC_MC_LSEL = 1;
  localparam int SSIC_MC_MODE_LO = 2;
  localparam int SSIC_MC_MODE_W = 2;
  localparam int SSIC_MC_USED_W = 4;

  // pin force mode codes
  localparam logic [1:0] SSIC_MODE_NORMAL = 2'h0;
  localparam logic [1:0] SSIC_MODE_TRI = 2'h1;
  localparam logic [1:0] SSIC_MODE_LOW = 2'h2;
  localparam logic [1:0] SSIC_MODE_HIGH = 2'h3;

  // second status register: sync loss condition and regain event
  localparam int SSIC_SR2_IDX = 1;
  localparam int SSIC_SYNC_LOSS_BIT = 0;
  localparam int SSIC_SYNC_REGAIN_BIT = 4;

  // summary split: low summary holds status registers one to eight
  localparam int SSIC_SUM_LO_W = 8;

  // reset values
  localparam logic [7:0] SSIC_RST_BYTE = 8'h00;
  localparam logic [3:0] SSIC_RST_MASTER = 4'h0;

  // soft reset sequencer states
  typedef enum logic [1:0] {
    SSIC_SRST_IDLE = 2'b01,
    SSIC_SRST_CLEAR = 2'b10
  } ssic_srst_e;

endpackage

/* File: ssic_status_slice.sv */
// one latched status register with write-then-read update and interrupt source
`timescale 1ns/1ps

module ssic_status_slice
  import ssic_pkg::*;
#(
  parameter logic [7:0] DBL_BITS = 8'h00
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic clear_in,
  input wire logic [7:0] src_in,
  input wire logic upd_we_in,
  input wire logic [7:0] sel_in,
  output logic [7:0] read_out,
  output logic [7:0] irq_src_out
);

  logic [7:0] latch_q;
  logic [7:0] prev_q;
  logic [7:0] dbl_q;
  logic [7:0] read_q;
  logic [7:0] upd;

  // only a write to this register selects bits for update
  assign upd = upd_we_in ? sel_in : SSIC_RST_BYTE;

  // latch: a live source wins over the update clear
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || clear_in) begin
      latch_q <= SSIC_RST_BYTE;
    end else begin
      latch_q <= src_in | (latch_q & ~upd);
    end
  end

  // readable copy refreshed only where a one was written
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || clear_in) begin
      read_q <= SSIC_RST_BYTE;
    end else begin
      read_q <= (upd & (latch_q | src_in)) | (~upd & read_q);
    end
  end

  // previous source level for edge detection
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || clear_in) begin
      prev_q <= SSIC_RST_BYTE;
    end else begin
      prev_q <= src_in;
    end
  end

  // double bits pend on both edges; new edge beats the clear
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || clear_in) begin
      dbl_q <= SSIC_RST_BYTE;
    end else begin
      dbl_q <= DBL_BITS & ((src_in ^ prev_q) | (dbl_q & ~upd));
    end
  end

  // double bits interrupt on edges, others on the latch
  assign irq_src_out = (DBL_BITS & dbl_q) | (~DBL_BITS & latch_q);
  assign read_out = read_q;

  ////////////////////////////////////////////////////////////////////////

  property p_latch_hold;
    @(posedge ref_clk_in) disable iff (!rst_n_in || clear_in)
      1'b1 |=> ((latch_q ^ $past(latch_q)) & $past(latch_q) & ~$past(upd)) == 8'h00;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched status bit lost without update");

  property p_cond_persist;
    @(posedge ref_clk_in) disable iff (!rst_n_in || clear_in)
      1'b1 |=> ($past(src_in) & ~latch_q) == 8'h00;
  endproperty
  a_cond_persist: assert property (p_cond_persist) else $error("active source not latched");

  property p_read_hold;
    @(posedge ref_clk_in) disable iff (!rst_n_in || clear_in)
      1'b1 |=> ((read_q ^ $past(read_q)) & ~$past(upd)) == 8'h00;
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("unselected readable bit changed");

  property p_dbl_edge;
    @(posedge ref_clk_in) disable iff (!rst_n_in || clear_in)
      1'b1 |=> (DBL_BITS & ($past(src_in) ^ $past(prev_q)) & ~dbl_q) == 8'h00;
  endproperty
  a_dbl_edge: assert property (p_dbl_edge) else $error("double bit edge did not pend");

endmodule // ssic_status_slice

/* File: ssic_status_interrupt_control.sv */
// master control, status latching, masks and interrupt summary of one transceiver
// Function
// - soft reset rising edge clears all registers
// - soft reset bit clears itself afterwards
// - line standard bit selects T1 or E1
// - pin force modes: normal, tristate, low, high
// - each status register has its own mask
// - only status registers raise interrupts
// - power-up clears writable registers and masks
// - status bit latches until host reads it
// - event bit clears on read, needs new event
// - condition bit stays set while condition lasts
// - written ones refresh readable bits, zeros hold
// - double bits interrupt on set and clear
// - sync loss condition, separate regained event
// - information registers never interrupt; live one direct
// - two summaries flag requesting status registers
`timescale 1ns/1ps

module ssic_status_interrupt_control
  import ssic_pkg::*;
#(
  parameter logic [SSIC_SRC_W-1:0] DBL_BITS = '0,
  parameter logic [7:0] INFO_DBL_BITS = 8'h00
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [SSIC_AW-1:0] addr_in,
  input wire logic [SSIC_DW-1:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [SSIC_DW-1:0] rd_data_out,
  input wire logic [SSIC_SRC_W-1:0] status_src_in,
  input wire logic sync_loss_in,
  input wire logic [7:0] info_src_in,
  input wire logic [7:0] live_sync_info_in,
  output logic line_standard_e1_out,
  output logic pins_tristate_out,
  output logic host_port_tristate_out,
  output logic pins_force_low_out,
  output logic pins_force_high_out,
  output logic int_n_out
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  ssic_srst_e state_q;
  logic [SSIC_MC_USED_W-1:0] master_q;
  logic clear_all;
  logic [1:0] pin_mode;
  logic sync_prev_q;
  logic regain;
  logic [7:0] sr2_ovr;
  logic [7:0] sr2_src;
  logic [7:0] src_vec [SSIC_NUM_SR];
  logic [7:0] mask_q [SSIC_NUM_SR];
  logic [7:0] sr_read [SSIC_NUM_SR];
  logic [7:0] sr_irq_src [SSIC_NUM_SR];
  logic [SSIC_NUM_SR-1:0] upd_we;
  logic [SSIC_NUM_SR-1:0] summ;
  logic [SSIC_NUM_SR-1:0] mask_nz;
  logic summ_any;
  logic int_n_q;
  logic info_upd_we;
  logic [7:0] info_read;
  logic [SSIC_DW-1:0] rd_mux;
  logic [SSIC_DW-1:0] rd_data_q;
  logic master_wr;

  // register offset decode shared by the write and read paths
  function automatic logic ssic_hit(input logic [7:0] a, input logic [7:0] base, input int idx);
    logic [7:0] off;
    off = base + 8'(idx);
    return a == off;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // master control and soft reset

  assign master_wr = wr_in && ssic_hit(addr_in, SSIC_OFF_MASTER, 0);

  // one clearing cycle after a 0-to-1 write of the trigger bit
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      state_q <= SSIC_SRST_IDLE;
    end else begin
      case (state_q)
        SSIC_SRST_IDLE: begin
          if (master_wr && wr_data_in[SSIC_MC_SRST] && !master_q[SSIC_MC_SRST]) begin
            state_q <= SSIC_SRST_CLEAR;
          end
        end
        SSIC_SRST_CLEAR: begin
          state_q <= SSIC_SRST_IDLE;
        end
        default: begin
          state_q <= SSIC_SRST_IDLE;
        end
      endcase
    end
  end

  // clearing beats any write landing in the same cycle
  assign clear_all = (state_q == SSIC_SRST_CLEAR);

  // upper unused bits are dropped, so they read back as zero
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || clear_all) begin
      master_q <= SSIC_RST_MASTER;
    end else if (master_wr) begin
      master_q <= wr_data_in[SSIC_MC_USED_W-1:0];
    end
  end

  // mode outputs decode straight from the stored master bits
  assign pin_mode = master_q[SSIC_MC_MODE_LO +: SSIC_MC_MODE_W];
  assign line_standard_e1_out = master_q[SSIC_MC_LSEL];
  assign pins_tristate_out = (pin_mode == SSIC_MODE_TRI);
  assign host_port_tristate_out = (pin_mode == SSIC_MODE_TRI);
  assign pins_force_low_out = (pin_mode == SSIC_MODE_LOW);
  assign pins_force_high_out = (pin_mode == SSIC_MODE_HIGH);

  ////////////////////////////////////////////////////////////////////////
  // sync loss handling for the second status register

  // sync input comes from framer logic on this clock, no synchroniser
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || clear_all) begin
      sync_prev_q <= 1'b0;
    end else begin
      sync_prev_q <= sync_loss_in;
    end
  end

  // regain is a one-cycle event on the falling edge of sync loss
  assign regain = sync_prev_q & ~sync_loss_in;
  assign sr2_ovr = (8'h01 << SSIC_SYNC_LOSS_BIT) | (8'h01 << SSIC_SYNC_REGAIN_BIT);
  assign sr2_src = (status_src_in[SSIC_SR2_IDX*SSIC_DW +: SSIC_DW] & ~sr2_ovr)
                 | (8'(sync_loss_in) << SSIC_SYNC_LOSS_BIT)
                 | (8'(regain) << SSIC_SYNC_REGAIN_BIT);

  ////////////////////////////////////////////////////////////////////////
  // status registers and their masks

  for (genvar i = 0; i < SSIC_NUM_SR; i++) begin : g_sr
    if (i == SSIC_SR2_IDX) begin : g_src_sr2
      assign src_vec[i] = sr2_src;
    end else begin : g_src_plain
      assign src_vec[i] = status_src_in[i*SSIC_DW +: SSIC_DW];
    end

    assign upd_we[i] = wr_in && ssic_hit(addr_in, SSIC_OFF_SR_BASE, i);

    // mask bits gate this register only
    always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in || clear_all) begin
        mask_q[i] <= SSIC_RST_BYTE;
      end else if (wr_in && ssic_hit(addr_in, SSIC_OFF_IMR_BASE, i)) begin
        mask_q[i] <= wr_data_in;
      end
    end

    ssic_status_slice #(
      .DBL_BITS(DBL_BITS[i*SSIC_DW +: SSIC_DW])
    ) u_sr (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .clear_in(clear_all),
      .src_in(src_vec[i]),
      .upd_we_in(upd_we[i]),
      .sel_in(wr_data_in),
      .read_out(sr_read[i]),
      .irq_src_out(sr_irq_src[i])
    );

    // a summary bit needs a set source under a set mask
    assign summ[i] = |(sr_irq_src[i] & mask_q[i]);
    assign mask_nz[i] = |mask_q[i];
  end

  ////////////////////////////////////////////////////////////////////////
  // latched information register, same update scheme, no interrupt path

  assign info_upd_we = wr_in && ssic_hit(addr_in, SSIC_OFF_INFO_LATCHED, 0);

  ssic_status_slice #(
    .DBL_BITS(INFO_DBL_BITS)
  ) u_info (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .clear_in(clear_all),
    .src_in(info_src_in),
    .upd_we_in(info_upd_we),
    .sel_in(wr_data_in),
    .read_out(info_read),
    .irq_src_out()
  );

  ////////////////////////////////////////////////////////////////////////
  // interrupt output

  // status registers are the only contributors to the request
  assign summ_any = |summ;

  // registered so the pin never glitches on decode
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in || clear_all) begin
      int_n_q <= 1'b1;
    end else begin
      int_n_q <= ~summ_any;
    end
  end

  assign int_n_out = int_n_q;

  ////////////////////////////////////////////////////////////////////////
  // register read path

  // live info bypasses the latch and needs no prior write
  always_comb begin
    rd_mux = SSIC_RST_BYTE;
    if (ssic_hit(addr_in, SSIC_OFF_MASTER, 0)) begin
      rd_mux = {{(SSIC_DW-SSIC_MC_USED_W){1'b0}}, master_q};
    end else if (ssic_hit(addr_in, SSIC_OFF_SUM_LO, 0)) begin
      rd_mux = summ[SSIC_SUM_LO_W-1:0];
    end else if (ssic_hit(addr_in, SSIC_OFF_SUM_HI, 0)) begin
      rd_mux = {{(SSIC_DW-1){1'b0}}, summ[SSIC_NUM_SR-1]};
    end else if (ssic_hit(addr_in, SSIC_OFF_INFO_LATCHED, 0)) begin
      rd_mux = info_read;
    end else if (ssic_hit(addr_in, SSIC_OFF_INFO_LIVE, 0)) begin
      rd_mux = live_sync_info_in;
    end else begin
      for (int k = 0; k < SSIC_NUM_SR; k++) begin
        if (ssic_hit(addr_in, SSIC_OFF_SR_BASE, k)) begin
          rd_mux = sr_read[k];
        end
        if (ssic_hit(addr_in, SSIC_OFF_IMR_BASE, k)) begin
          rd_mux = mask_q[k];
        end
      end
    end
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rd_data_q <= SSIC_RST_BYTE;
    end else if (rd_in) begin
      rd_data_q <= rd_mux;
    end else begin
      rd_data_q <= SSIC_RST_BYTE;
    end
  end

  assign rd_data_out = rd_data_q;

  ////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_srst_write;
    master_wr && wr_data_in[SSIC_MC_SRST] && !master_q[SSIC_MC_SRST] && state_q == SSIC_SRST_IDLE;
  endsequence

  sequence s_clear_done;
    (state_q == SSIC_SRST_CLEAR) ##1 (master_q == SSIC_RST_MASTER && mask_nz == '0 && int_n_out);
  endsequence

  property p_srst_clear;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      s_srst_write |=> s_clear_done;
  endproperty
  a_srst_clear: assert property (p_srst_clear) else $error("soft reset did not clear registers");

  property p_srst_self;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      state_q == SSIC_SRST_CLEAR |=> !master_q[SSIC_MC_SRST] && state_q == SSIC_SRST_IDLE;
  endproperty
  a_srst_self: assert property (p_srst_self) else $error("soft reset bit did not clear itself");

  property p_lsel;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      master_wr && state_q == SSIC_SRST_IDLE
        |=> line_standard_e1_out == $past(wr_data_in[SSIC_MC_LSEL]);
  endproperty
  a_lsel: assert property (p_lsel) else $error("line standard output wrong after write");

  property p_mode_low;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      master_wr && state_q == SSIC_SRST_IDLE
        && wr_data_in[SSIC_MC_MODE_LO +: SSIC_MC_MODE_W] == SSIC_MODE_LOW
        |=> pins_force_low_out && !pins_force_high_out && !host_port_tristate_out && !pins_tristate_out;
  endproperty
  a_mode_low: assert property (p_mode_low) else $error("force low mode not applied");

  property p_mode_tri;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      master_wr && state_q == SSIC_SRST_IDLE
        && wr_data_in[SSIC_MC_MODE_LO +: SSIC_MC_MODE_W] == SSIC_MODE_TRI
        |=> pins_tristate_out && host_port_tristate_out && !pins_force_low_out;
  endproperty
  a_mode_tri: assert property (p_mode_tri) else $error("tristate mode not applied");

  // checked through the registered pin, not the summary decode itself
  property p_mask_gate;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      mask_nz == '0 |=> int_n_out;
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("summary set with mask cleared");

  property p_reset_quiet;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      $past(rst_n_in) == 1'b0 |-> int_n_out && mask_nz == '0 && master_q == SSIC_RST_MASTER;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("state not clear after reset");

  property p_irq_follow;
    @(posedge ref_clk_in) disable iff (!rst_n_in || clear_all)
      1'b1 |=> int_n_out == !$past(summ_any);
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("interrupt pin does not follow summary");

  property p_summary_hi;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      rd_in && ssic_hit(addr_in, SSIC_OFF_SUM_HI, 0)
        |=> rd_data_out[SSIC_DW-1:1] == '0 && rd_data_out[0] == $past(summ[SSIC_NUM_SR-1]);
  endproperty
  a_summary_hi: assert property (p_summary_hi) else $error("high summary read wrong");

  property p_regain;
    @(posedge ref_clk_in) disable iff (!rst_n_in || clear_all)
      $fell(sync_loss_in) |=> sr_irq_src[SSIC_SR2_IDX][SSIC_SYNC_REGAIN_BIT];
  endproperty
  a_regain: assert property (p_regain) else $error("sync regained event not latched");

endmodule // ssic_status_interrupt_control

/* File: ssic_host_model.sv */
// host microprocessor model driving the register port of the control block
`timescale 1ns/1ps

module ssic_host_model
  import ssic_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic [SSIC_DW-1:0] rd_data_in,
  output logic [SSIC_AW-1:0] addr_out,
  output logic [SSIC_DW-1:0] wr_data_out,
  output logic wr_out,
  output logic rd_out
);
  logic [7:0] mask_shadow [SSIC_NUM_SR];

  ////////////////////////////////////////
  // idle bus at time zero, no masks known yet
  initial begin
    addr_out = 8'h00;
    wr_data_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    foreach (mask_shadow[i]) mask_shadow[i] = 8'h00;
  end

  // one write; released lines flip so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = (a == SSIC_OFF_MASTER) ? (d & 8'h0f) : d;
    @(posedge ref_clk_in);
    addr_out <= a;
    wr_data_out <= v;
    wr_out <= 1'b1;
    @(posedge ref_clk_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wr_data_out <= ~v;
    if (a >= SSIC_OFF_IMR_BASE && a < SSIC_OFF_IMR_BASE + 8'h09)
      mask_shadow[a - SSIC_OFF_IMR_BASE] = v;
  endtask

  // one read; data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge ref_clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    #1;
    d = rd_data_in;
  endtask

  // selection write with the read right behind it, no gap
  task automatic rd_status(input logic [7:0] a, input logic [7:0] sel, output logic [7:0] d);
    @(posedge ref_clk_in);
    addr_out <= a;
    wr_data_out <= sel;
    wr_out <= 1'b1;
    @(posedge ref_clk_in);
    wr_out <= 1'b0;
    rd_out <= 1'b1;
    wr_data_out <= ~sel;
    @(posedge ref_clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    #1;
    d = rd_data_in;
  endtask

  // service routine: summaries first, masks off while servicing, then restored
  task automatic service(output logic [15:0] sums, output logic [7:0] vals [SSIC_NUM_SR]);
    logic [7:0] saved [SSIC_NUM_SR];
    logic [7:0] lo;
    logic [7:0] hi;
    saved = mask_shadow;
    rd(SSIC_OFF_SUM_LO, lo);
    rd(SSIC_OFF_SUM_HI, hi);
    sums = {hi, lo};
    for (int i = 0; i < SSIC_NUM_SR; i++)
      wr(SSIC_OFF_IMR_BASE + 8'(i), 8'h00);
    for (int i = 0; i < SSIC_NUM_SR; i++) begin
      vals[i] = 8'h00;
      if (sums[i])
        rd_status(SSIC_OFF_SR_BASE + 8'(i), 8'hff, vals[i]);
    end
    for (int i = 0; i < SSIC_NUM_SR; i++)
      wr(SSIC_OFF_IMR_BASE + 8'(i), saved[i]);
  endtask
endmodule // ssic_host_model

/* File: ssic_status_interrupt_control_test.sv */
// self-checking bench: host model, reference model and the control block
`timescale 1ns/1ps

module ssic_status_interrupt_control_test
  import ssic_pkg::*;
();
  localparam logic [SSIC_SRC_W-1:0] DBL = 72'h1 << 25; // reg4 bit1 interrupts on both edges
  logic ref_clk_in;
  logic rst_n_in;
  logic [7:0] addr;
  logic [7:0] wdat;
  logic wr;
  logic rd;
  logic [7:0] rdat;
  logic [SSIC_SRC_W-1:0] src;
  logic sync_loss;
  logic [7:0] info;
  logic [7:0] live;
  logic e1;
  logic tri_p;
  logic tri_h;
  logic f_lo;
  logic f_hi;
  logic int_n;
  int miscompares;
  int total_checks;
  int m_lat [9];
  int m_cpy [9];
  int m_msk [9];
  int m_src [9];
  int ks [7] = '{0, 2, 4, 5, 6, 7, 8};
  int k;
  int b;
  logic [7:0] d;
  logic [7:0] v;
  logic [15:0] sums;
  logic [7:0] vals [SSIC_NUM_SR];

  ////////////////////////////////////////
  ssic_host_model host (.ref_clk_in(ref_clk_in), .rd_data_in(rdat), .addr_out(addr), .wr_data_out(wdat),
    .wr_out(wr), .rd_out(rd));
  ssic_status_interrupt_control #(.DBL_BITS(DBL)) uut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .addr_in(addr), .wr_data_in(wdat), .wr_in(wr), .rd_in(rd), .rd_data_out(rdat), .status_src_in(src),
    .sync_loss_in(sync_loss), .info_src_in(info), .live_sync_info_in(live), .line_standard_e1_out(e1),
    .pins_tristate_out(tri_p), .host_port_tristate_out(tri_h), .pins_force_low_out(f_lo),
    .pins_force_high_out(f_hi), .int_n_out(int_n));

  // 40 MHz clock
  initial ref_clk_in = 1'b0;
  always #12.5 ref_clk_in = ~ref_clk_in;

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // bounded wait on the interrupt line; running out ends the run
  task automatic wait_int(input logic lvl);
    for (int n = 0; n < 8 && int_n !== lvl; n++) @(negedge ref_clk_in);
    if (int_n !== lvl) begin
      miscompares++;
      $display("Error at %0t: interrupt wait ran out", $time);
      end_sim();
    end
  endtask

  // reference copy follows select-write update, set wins over clear
  task automatic st_read(input int k, input int sel);
    logic [7:0] got;
    host.rd_status(SSIC_OFF_SR_BASE + 8'(k), 8'(sel), got);
    m_cpy[k] = (m_cpy[k] & ~sel) | ((m_lat[k] | m_src[k]) & sel);
    m_lat[k] = (m_lat[k] & ~sel) | (m_src[k] & sel);
    chk(got, 8'(m_cpy[k]));
  endtask

  // summaries and interrupt line against the reference latches and masks
  task automatic chk_sum();
    int s;
    s = 0;
    for (int i = 0; i < 9; i++)
      if ((m_lat[i] & m_msk[i]) != 0)
        s |= 1 << i;
    host.rd(SSIC_OFF_SUM_LO, d);
    chk(d, s[7:0]);
    host.rd(SSIC_OFF_SUM_HI, d);
    chk(d, s[15:8]);
    @(negedge ref_clk_in);
    chk({7'h0, int_n}, {7'h0, s == 0});
  endtask

  task automatic pulse(input int k, input int b);
    @(posedge ref_clk_in);
    src[8*k+b] <= 1'b1;
    @(posedge ref_clk_in);
    src[8*k+b] <= 1'b0;
    m_lat[k] |= 1 << b;
  endtask

  task automatic mask(input int k, input int v);
    host.wr(SSIC_OFF_IMR_BASE + 8'(k), 8'(v));
    m_msk[k] = v;
  endtask

  // main sequence
  initial begin
    rst_n_in = 1'b0;
    src = '0;
    sync_loss = 1'b0;
    info = 8'h00;
    live = 8'h00;
    void'($urandom(55507));
    repeat (2) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    host.rd(SSIC_OFF_MASTER, d);
    chk(d, 8'h00);
    for (int i = 0; i < 9; i++) begin
      host.rd(SSIC_OFF_IMR_BASE + 8'(i), d);
      chk(d, 8'h00);
    end
    host.rd(8'h30, d);
    chk(d, 8'h00);
    chk({3'h0, e1, tri_p, tri_h, f_lo, f_hi}, 8'h00);
    chk_sum();
    $display("test reset done");
    for (int m = 0; m < 4; m++)
      for (int l = 0; l < 2; l++) begin
        v = 8'((m << 2) | (l << 1));
        host.wr(SSIC_OFF_MASTER, v);
        host.rd(SSIC_OFF_MASTER, d);
        chk(d, v);
        chk({7'h0, e1}, 8'(l));
        chk({4'h0, tri_p, tri_h, f_lo, f_hi}, {4'h0, m == 1, m == 1, m == 2, m == 3});
      end
    host.wr(SSIC_OFF_MASTER, 8'h00);
    $display("test master done");
    k = ks[$urandom_range(0, 6)];
    b = $urandom_range(0, 7);
    pulse(k, b);
    chk_sum();
    mask(k, 1 << b);
    wait_int(1'b0);
    st_read(k, $urandom & ~(1 << b));
    chk_sum();
    st_read(k, 1 << b);
    chk_sum();
    st_read(k, 8'hff);
    $display("test event done");
    k = ks[$urandom_range(0, 6)];
    v = 8'($urandom_range(1, 255));
    @(posedge ref_clk_in);
    src[8*k +: 8] <= v;
    m_src[k] = v;
    m_lat[k] |= v;
    st_read(k, 8'hff);
    st_read(k, 8'hff);
    @(posedge ref_clk_in);
    src[8*k +: 8] <= 8'h00;
    m_src[k] = 0;
    st_read(k, 8'hff);
    st_read(k, 8'hff);
    chk_sum();
    $display("test condition done");
    mask(1, 8'h11);
    @(posedge ref_clk_in);
    sync_loss <= 1'b1;
    m_src[1] = 1;
    m_lat[1] |= 1;
    wait_int(1'b0);
    st_read(1, 8'h11);
    @(posedge ref_clk_in);
    sync_loss <= 1'b0;
    m_src[1] = 0;
    m_lat[1] |= 8'h10;
    chk_sum();
    st_read(1, 8'h11);
    chk_sum();
    $display("test sync done");
    for (int i = 0; i < 9; i++)
      mask(i, 8'hff);
    v = 8'($urandom_range(1, 255));
    @(posedge ref_clk_in);
    info <= v;
    live <= ~v;
    @(posedge ref_clk_in);
    info <= 8'h00;
    chk_sum();
    host.rd_status(SSIC_OFF_INFO_LATCHED, 8'hff, d);
    chk(d, v);
    host.rd(SSIC_OFF_INFO_LIVE, d);
    chk(d, ~v);
    $display("test info done");
    @(posedge ref_clk_in);
    src[25] <= 1'b1;
    wait_int(1'b0);
    host.rd_status(SSIC_OFF_SR_BASE + 8'h03, 8'h02, d);
    chk(d, 8'h02);
    wait_int(1'b1);
    @(posedge ref_clk_in);
    src[25] <= 1'b0;
    wait_int(1'b0);
    host.rd_status(SSIC_OFF_SR_BASE + 8'h03, 8'h02, d);
    chk(d, 8'h02);
    wait_int(1'b1);
    $display("test double done");
    k = ks[$urandom_range(0, 6)];
    b = $urandom_range(0, 7);
    pulse(k, b);
    wait_int(1'b0);
    host.service(sums, vals);
    chk(sums[7:0], 8'(1 << k));
    chk(sums[15:8], 8'((1 << k) >> 8));
    chk(vals[k], 8'(1 << b));
    m_lat[k] = 0;
    host.rd(SSIC_OFF_IMR_BASE + 8'(k), d);
    chk(d, 8'hff);
    chk_sum();
    $display("test handler done");
    host.wr(SSIC_OFF_MASTER, 8'h02);
    host.rd_status(SSIC_OFF_MASTER, 8'h03, d);
    chk(d, 8'h03);
    host.rd(SSIC_OFF_MASTER, d);
    chk(d, 8'h00);
    host.rd(SSIC_OFF_IMR_BASE, d);
    chk(d, 8'h00);
    chk({7'h0, e1}, 8'h00);
    foreach (m_msk[i]) m_msk[i] = 0;
    pulse(0, 0);
    chk_sum();
    $display("test soft reset done");
    end_sim();
  end
endmodule // ssic_status_interrupt_control_test
